// >>> include/mbab_cfg.svh
`ifndef MBAB_CFG_SVH
`define MBAB_CFG_SVH
// Summary of operation
// - program read bus has 22-bit address and 32-bit data
// - data read and data write buses each own 32-bit address and data
// - a 32-bit access completes in one bus cycle, never split
// - fetch, data read and data write may run in the same cycle
// - each attached target arbitrates accesses arriving together
// - priority: data write, program write, data read, program read, fetch
// - bridge folds all buses onto one 16-bit address peripheral bus
// - narrow peripheral frame accepts 16-bit accesses only
// - wide peripheral frame accepts 16-bit and 32-bit accesses
// ==========================================================================
`define MBAB_PA_W      22
`define MBAB_DA_W      32
`define MBAB_D_W       32
`define MBAB_PB_AW     16
`define MBAB_NSRC      5
// peripheral window decode on upper address bits of the 32-bit space
`define MBAB_PF_HI     31
`define MBAB_PF_LO     16
`define MBAB_PF_WIDE   16'h0000
`define MBAB_PF_NARROW 16'h0001
// zero fill for read-only sources and for the idle upper half-word lane
`define MBAB_ZERO_W    32'h0000_0000
`define MBAB_HALF_W    16
`define MBAB_HALF_ZERO 16'h0000
// source indices, index 0 is highest priority
`define MBAB_S_DWR     0
`define MBAB_S_PWR     1
`define MBAB_S_DRD     2
`define MBAB_S_PRD     3
`define MBAB_S_FET     4
`endif

// >>> include/mbab_pkg.sv
package mbab_pkg;
  // one request presented to the peripheral bridge
  typedef struct packed {
    logic        vld;
    logic        wr;
    logic        wide;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mbab_req_type;
  typedef enum logic [1:0] {
    MBAB_IDLE = 2'b01,
    MBAB_BUSY = 2'b10
  } mbab_state_type;
endpackage

// >>> include/mbab_arb_if.sv
`timescale 1ns/1ps
// grant vector between the priority picker and the bridge
interface mbab_arb_if;
  logic [4:0] req;
  logic [4:0] gnt;
  modport pick (input req, output gnt);
  modport user (output req, input gnt);
endinterface

// >>> hdl/mbab_prio.sv
`timescale 1ns/1ps
`include "mbab_cfg.svh"
module mbab_prio (
  // request and grant vectors
  mbab_arb_if.pick arb
);
  import mbab_pkg::*;

  // ==========================================================================
  // fixed priority pick, lowest index wins
  function automatic logic [4:0] mbab_first(input logic [4:0] r);
    logic [4:0] g;
    g = 5'h00;
    for (int i = `MBAB_NSRC - 1; i >= 0; i--) begin
      if (r[i]) begin
        g = 5'h00;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction
  assign arb.gnt = mbab_first(arb.req);
endmodule

// >>> hdl/mbab_bridge.sv
`timescale 1ns/1ps
`include "mbab_cfg.svh"
module mbab_bridge
  import mbab_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_b_in,
  // program bus: fetch, program read, program write
  input  wire logic                     fetch_req_in,
  input  wire logic                     prd_req_in,
  input  wire logic                     pwr_req_in,
  input  wire logic [`MBAB_PA_W-1:0]    prog_addr_in,
  input  wire logic [`MBAB_D_W-1:0]     prog_wdata_in,
  input  wire logic                     prog_wide_in,
  // data read bus
  input  wire logic                     drd_req_in,
  input  wire logic [`MBAB_DA_W-1:0]    drd_addr_in,
  input  wire logic                     drd_wide_in,
  // data write bus
  input  wire logic                     dwr_req_in,
  input  wire logic [`MBAB_DA_W-1:0]    dwr_addr_in,
  input  wire logic [`MBAB_D_W-1:0]     dwr_wdata_in,
  input  wire logic                     dwr_wide_in,
  // answers to the core
  output logic [`MBAB_NSRC-1:0]         done_out,
  output logic [`MBAB_NSRC-1:0]         stall_out,
  output logic [`MBAB_NSRC-1:0]         err_out,
  output logic [`MBAB_D_W-1:0]          prog_rdata_out,
  output logic [`MBAB_D_W-1:0]          drd_rdata_out,
  // peripheral bus
  output logic                          pb_sel_out,
  output logic                          pb_wr_out,
  output logic                          pb_wide_out,
  output logic                          pb_narrow_frame_out,
  output logic [`MBAB_PB_AW-1:0]        pb_addr_out,
  output logic [`MBAB_D_W-1:0]          pb_wdata_out,
  input  wire logic [`MBAB_D_W-1:0]     pb_rdata_in
);
  import mbab_pkg::*;

  // ==========================================================================
  // state
  // one register image holds every output but stall, so those outputs come straight
  // from flip-flops; done and err reach the core one clock after the grant, read
  // data two clocks after it; requests are not copied in: each requester holds
  // its level until done or err, which is what lets a loser simply stall and be picked up later
  typedef struct packed {
    logic [`MBAB_NSRC-1:0] done;
    logic [`MBAB_NSRC-1:0] err;
    logic [`MBAB_D_W-1:0]  prog_rdata;
    logic [`MBAB_D_W-1:0]  drd_rdata;
    logic                  sel;
    logic                  wr;
    logic                  wide;
    logic                  narrow;
    logic [`MBAB_PB_AW-1:0] addr;
    logic [`MBAB_D_W-1:0]  wdata;
  } mbab_st_type;

  // ==========================================================================
  // limits a user must know
  // - one peripheral transfer per cycle; five frame requests at once take
  //   five cycles and the lowest source waits through all of them
  // - a request still high the cycle after its done is taken again, so the
  //   core must drop it unless it wants a second access
  // - read data is latched only from the bus cycle this block ran; the
  //   peripheral need not hold it any longer
  // - no wait states: every peripheral answers in the cycle it is selected
  // - the peripheral bus is not parked: address and data keep the last
  //   transfer's values while select is low

  mbab_st_type st_q;
  mbab_st_type st_d;
  mbab_req_type req [`MBAB_NSRC];
  logic [`MBAB_NSRC-1:0] rq;
  logic [`MBAB_NSRC-1:0] gnt;
  logic [`MBAB_NSRC-1:0] hit;
  mbab_arb_if arb ();

  // ==========================================================================
  // gather the five sources into one table, indexed by priority
  // program addresses are shorter than the frame map; pad with zeros so every
  // source is decoded against the same 32-bit space
  function automatic logic [`MBAB_DA_W-1:0] mbab_prog_addr(
    input logic [`MBAB_PA_W-1:0] a
  );
    return {{(`MBAB_DA_W - `MBAB_PA_W){1'b0}}, a};
  endfunction

  always_comb begin
    // data write bus, on wires of its own
    req[`MBAB_S_DWR] = '{dwr_req_in, 1'b1, dwr_wide_in, dwr_addr_in, dwr_wdata_in};
    // program write shares the program address with fetch and program read
    req[`MBAB_S_PWR] = '{pwr_req_in, 1'b1, prog_wide_in,
                         mbab_prog_addr(prog_addr_in), prog_wdata_in};
    // reads carry no write data; zero keeps the write lanes quiet
    req[`MBAB_S_DRD] = '{drd_req_in, 1'b0, drd_wide_in, drd_addr_in, `MBAB_ZERO_W};
    // program read takes its width from the program bus
    req[`MBAB_S_PRD] = '{prd_req_in, 1'b0, prog_wide_in,
                         mbab_prog_addr(prog_addr_in), `MBAB_ZERO_W};
    // a fetch is always a full instruction word
    req[`MBAB_S_FET] = '{fetch_req_in, 1'b0, 1'b1,
                         mbab_prog_addr(prog_addr_in), `MBAB_ZERO_W};
  end

  // ==========================================================================
  // only requests that land in a peripheral frame compete here; others pass
  // to their memory unimpeded, so all three buses run in one cycle
  // frame number: the upper half-word of the 32-bit address
  function automatic logic [`MBAB_PF_HI-`MBAB_PF_LO:0] mbab_frame(
    input logic [`MBAB_DA_W-1:0] a
  );
    return a[`MBAB_PF_HI:`MBAB_PF_LO];
  endfunction

  // the narrow frame takes half-words only
  function automatic logic mbab_is_narrow(input logic [`MBAB_DA_W-1:0] a);
    return mbab_frame(a) == `MBAB_PF_NARROW;
  endfunction

  // any other upper half-word belongs to a memory outside the bridge
  function automatic logic mbab_in_pf(input logic [`MBAB_DA_W-1:0] a);
    return (mbab_frame(a) == `MBAB_PF_WIDE) || mbab_is_narrow(a);
  endfunction

  // half-word reads hand back the low lane zero-extended; the upper lane of
  // a narrow peripheral is undefined and must not leak to the core
  function automatic logic [`MBAB_D_W-1:0] mbab_fit_rd(
    input logic                 wide,
    input logic [`MBAB_D_W-1:0] d
  );
    return wide ? d : {`MBAB_HALF_ZERO, d[`MBAB_HALF_W-1:0]};
  endfunction

  always_comb begin
    for (int i = 0; i < `MBAB_NSRC; i++) begin
      hit[i] = req[i].vld && mbab_in_pf(req[i].addr);
      // a request granted one cycle ago has been served; do not reissue
      rq[i]  = hit[i] && !st_q.done[i] && !st_q.err[i];
    end
  end

  // the picker is plain logic, so the grant settles in the same cycle as the
  // requests and the register image acts on it at the next edge
  assign arb.req = rq;
  assign gnt     = arb.gnt;
  mbab_prio u_prio (.arb(arb));

  // losers see stall and must hold their request until done or err; stall is
  // combinational so the core can freeze in the very cycle it loses, and a
  // request outside both frames never stalls here
  assign stall_out = rq & ~gnt;

  // ==========================================================================
  // one transfer per cycle, full 32 bits at once; the picker hands over a
  // one-hot grant, so at most one iteration below fires; a refused wide access
  // to the narrow frame raises err and leaves the peripheral bus idle
  always_comb begin
    st_d      = st_q;
    st_d.done = '0;
    st_d.err  = '0;
    st_d.sel  = 1'b0;
    st_d.wr   = 1'b0;
    for (int i = 0; i < `MBAB_NSRC; i++) begin
      if (gnt[i]) begin
        st_d.narrow = mbab_is_narrow(req[i].addr);
        if (st_d.narrow && req[i].wide) begin
          st_d.err[i] = 1'b1;
        end else begin
          st_d.sel   = 1'b1;
          st_d.wr    = req[i].wr;
          st_d.wide  = req[i].wide;
          st_d.addr  = req[i].addr[`MBAB_PB_AW-1:0];
          st_d.wdata = req[i].wdata;
          st_d.done[i] = 1'b1;
        end
      end
    end
    // read data returns the cycle after the strobe; it is held until the next
    // read on the same bus, so a write in between leaves it alone
    if (st_q.sel && !st_q.wr) begin
      if (st_q.done[`MBAB_S_DRD]) begin
        st_d.drd_rdata = mbab_fit_rd(st_q.wide, pb_rdata_in);
      end
      if (st_q.done[`MBAB_S_PRD] || st_q.done[`MBAB_S_FET]) begin
        st_d.prog_rdata = mbab_fit_rd(st_q.wide, pb_rdata_in);
      end
    end
  end

  // reset clears the image, so no stale done or err can mask a first request
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  // every output but stall is a plain copy of the register image
  assign done_out            = st_q.done;
  assign err_out             = st_q.err;
  assign prog_rdata_out      = st_q.prog_rdata;
  assign drd_rdata_out       = st_q.drd_rdata;
  assign pb_sel_out          = st_q.sel;
  assign pb_wr_out           = st_q.wr;
  assign pb_wide_out         = st_q.wide;
  assign pb_narrow_frame_out = st_q.narrow;
  assign pb_addr_out         = st_q.addr;
  assign pb_wdata_out        = st_q.wdata;
endmodule

// >>> sim/mbab_bridge_sva.sv
`timescale 1ns/1ps
`include "mbab_cfg.svh"
// ==========================================================
// bridge checker
module mbab_bridge_sva (
  // clock and reset
  input wire logic                  clk_in,
  input wire logic                  rst_b_in,
  // requests from the core
  input wire logic                  dwr_req_in,
  input wire logic                  fetch_req_in,
  input wire logic [`MBAB_DA_W-1:0] dwr_addr_in,
  input wire logic [`MBAB_PA_W-1:0] prog_addr_in,
  // answers and peripheral bus
  input wire logic [`MBAB_NSRC-1:0] done_out,
  input wire logic [`MBAB_NSRC-1:0] stall_out,
  input wire logic [`MBAB_NSRC-1:0] err_out,
  input wire logic [`MBAB_D_W-1:0]  drd_rdata_out,
  input wire logic                  pb_sel_out,
  input wire logic                  pb_wide_out,
  input wire logic                  pb_narrow_frame_out,
  input wire logic [`MBAB_D_W-1:0]  pb_rdata_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // live requests: in a frame and not just answered
  wire d_live = dwr_req_in && dwr_addr_in[31:17] == 15'h0000 && !done_out[0] && !err_out[0];
  wire f_live = fetch_req_in && prog_addr_in[21:17] == 5'h00 && !done_out[4] && !err_out[4];
  a_one_xfer: assert property ($onehot0(done_out))
    else $error("two transfers");
  a_sel_done: assert property (pb_sel_out == |done_out)
    else $error("sel without done");
  a_dwr_wins: assert property (d_live |=> done_out[0] || err_out[0])
    else $error("dwr late");
  a_dwr_no_stall: assert property (!stall_out[0])
    else $error("dwr stalled");
  a_fetch_stall: assert property (f_live && d_live |-> stall_out[4])
    else $error("no stall");
  a_fetch_served: assert property (f_live |-> ##[1:5] (done_out[4] || err_out[4]))
    else $error("fetch dropped");
  a_narrow_only: assert property (pb_sel_out && pb_narrow_frame_out |-> !pb_wide_out)
    else $error("wide on narrow frame");
  a_err_no_bus: assert property (|err_out |-> !pb_sel_out)
    else $error("refused but ran");
  a_rd_whole: assert property (done_out[2] && pb_wide_out |=>
    drd_rdata_out == $past(pb_rdata_in))
    else $error("read data split");
endmodule
bind mbab_bridge mbab_bridge_sva u_mbab_bridge_sva (.*);

// >>> sim/mbab_periph.sv
`timescale 1ns/1ps
// ==========================================================
// peripheral answering on the bridge bus
module mbab_periph (
  // bridge bus from the design
  input  wire logic        clk_in,
  input  wire logic        sel_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] addr_in,
  // read data back to the design
  output logic      [31:0] rdata_out
);
  logic [31:0] last_q = 32'h0;
  // address pattern on a read, else inverse of last so idle never looks valid
  always_comb rdata_out = (sel_in && !wr_in) ? {~addr_in, addr_in} : ~last_q;
  // remember what was shown
  always_ff @(posedge clk_in) last_q <= rdata_out;
endmodule

// >>> sim/mbab_bridge_tb.sv
`timescale 1ns/1ps
module mbab_bridge_tb;
  logic clk_in = 0, rst_b_in = 0, w = 0, sel, pwr, pwide, pnar;
  logic [4:0] rq = 0, m, done, err;
  logic [31:0] a = 0, wd = 0, prd, drd, prdata, pwd, pe;
  logic [15:0] padr;
  int n_mismatch = 0, check_count = 0, cyc = 0, pk = 0;
  always #12.5 clk_in = ~clk_in;
  mbab_bridge u_mbab_bridge (.clk_in, .rst_b_in, .fetch_req_in(rq[4]), .prd_req_in(rq[3]),
    .pwr_req_in(rq[1]), .prog_addr_in(a[21:0]), .prog_wdata_in(wd), .prog_wide_in(w),
    .drd_req_in(rq[2]), .drd_addr_in(a), .drd_wide_in(w), .dwr_req_in(rq[0]), .dwr_addr_in(a),
    .dwr_wdata_in(wd), .dwr_wide_in(w), .done_out(done), .stall_out(), .err_out(err),
    .prog_rdata_out(prd), .drd_rdata_out(drd), .pb_sel_out(sel), .pb_wr_out(pwr),
    .pb_wide_out(pwide), .pb_narrow_frame_out(pnar), .pb_addr_out(padr), .pb_wdata_out(pwd),
    .pb_rdata_in(prdata));
  mbab_periph u_mbab_periph (.clk_in, .sel_in(sel), .wr_in(pwr), .addr_in(padr),
    .rdata_out(prdata));
  // expected read word: the model answers with the inverted address above it
  function automatic logic [31:0] exp_rd(input logic [15:0] ad, input logic w32);
    return w32 ? {~ad, ad} : {16'h0000, ad};
  endfunction
  // ==========================================================
  // checks and closing
  task chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one edge, then the read data owed by the previous read
  task tick;
    @(posedge clk_in) #1;
    if (pk > 1) chk("rdata", pe, pk == 2 ? drd : prd);
    pk = 0;
  endtask
  // raise all requests of m, expect service in priority order
  task go(input logic [4:0] m);
    logic ew, rf;
    rq = m;
    for (int k = 0; k < 5; k++) if (m[k]) begin
      ew = w | (k == 4);
      rf = ew & a[16];
      tick();
      chk("done", rf ? 0 : 1 << k, done);
      chk("err", rf ? 1 << k : 0, err);
      if (!rf) chk("addr", a[15:0], padr);
      if (!rf) chk("kind", {a[16], ew, k < 2}, {pnar, pwide, pwr});
      if (!rf && k < 2) chk("wdata", ew ? wd : wd[15:0], ew ? pwd : pwd[15:0]);
      rq[k] = 0;
      pk = rf ? 0 : k;
      pe = exp_rd(a[15:0], ew);
    end
    tick();
  endtask
  // hang guard, far above the expected run
  always @(posedge clk_in) if (++cyc == 5000) begin
    n_mismatch++;
    results();
  end
  initial begin
    void'($urandom(32'h129868AF));
    repeat (4) @(posedge clk_in);
    #1 rst_b_in = 1;
    a = 32'h0000_1234;
    w = 1;
    wd = 32'hA5A5_5A5A;
    go(5'h15);
    go(5'h0E);
    a = 32'h0001_00F0;
    go(5'h01);
    w = 0;
    go(5'h04);
    $display("test corner done");
    repeat (60) begin
      m = 5'($urandom);
      if (m[0]) m[1] = 0;
      if (m[3]) m[4] = 0;
      a = $urandom & 32'h0001_FFFF;
      if ($countones(m) > 1) a[16] = 0;
      w = 1'($urandom);
      wd = $urandom;
      go(m);
    end
    $display("test random done");
    results();
  end
endmodule
